/* File: luhm_defines.vh */
/*
 * Constants of the LIN-capable serial transceiver: oversampling, character
 * and break lengths, header limits and state codes.
 * Assumes inclusion by bare name from the transceiver design files.
 */
`ifndef LUHM_DEFINES_VH
`define LUHM_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Bit timing
`define LUHM_OVERSAMPLE      5'd16
`define LUHM_SMP_LAST        4'hf
`define LUHM_SMP_MID         4'h8
`define LUHM_SMP_IDSTOP_END  4'hf

////////////////////////////////////////////////////////////////////////////////
// Character lengths in bit times
`define LUHM_CHAR_BITS_M0    4'ha
`define LUHM_CHAR_BITS_M1    4'hb
`define LUHM_BRK_BITS_M0     4'ha
`define LUHM_BRK_BITS_M1     4'hb
`define LUHM_BRK_BITS_LIN    4'hd
`define LUHM_IDLE_BITS_LIN   4'ha

////////////////////////////////////////////////////////////////////////////////
// Receiver frame and LIN header limits
`define LUHM_RX_STOP_BIT     4'h9
`define LUHM_BRK_DET_TICKS   8'hb0
`define LUHM_HDR_TMO_TICKS   10'h390
`define LUHM_HDR_LEN_ZERO    8'h00

////////////////////////////////////////////////////////////////////////////////
// State codes
`define LUHM_TX_IDLE         1'b0
`define LUHM_TX_RUN          1'b1
`define LUHM_KIND_DATA       2'h0
`define LUHM_KIND_IDLE       2'h1
`define LUHM_KIND_BREAK      2'h2
`define LUHM_RX_IDLE         1'b0
`define LUHM_RX_FRAME        1'b1
`define LUHM_H_WAIT          2'h0
`define LUHM_H_SYNC          2'h1
`define LUHM_H_ID            2'h2
`define LUHM_H_STOP          2'h3

`endif

/* File: luhm_tick.v */
/*
 * Oversampling tick divider: one-cycle enable at sixteen times the bit rate.
 * Assumes baud_div holds reference cycles per tick minus one.
 */
`timescale 1ns/1ps

module luhm_tick (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [15:0] baud_div,
  output reg         tick
);

  reg [15:0] count;

  ////////////////////////////////////////////////////////////////////////////////
  // Down counter with reload
  always @(posedge ref_clk) begin
    if (!resetn) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (count == 16'h0000) begin
      count <= baud_div;
      tick  <= 1'b1;
    end else begin
      count <= count - 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule // luhm_tick

/* File: luhm_uart.v */
/*
 * LIN-capable asynchronous transceiver: data, idle and break transmission,
 * sixteen-times oversampled reception, LIN slave header detection with
 * time-out and mute handling.
 * Assumes all inputs synchronous to ref_clk and single-cycle access strobes.
 */
// Function
// - Setting then clearing send_break_bit emits exactly one break character.
// - Plain serial break lasts 10 bits (M=0) or 11 bits (M=1), doubled if send_break_bit stays set to its end.
// - Breaks repeat while send_break_bit stays set; none extra after clearing.
// - LIN master mode when LIN enable set and word-length bit clear.
// - LIN master break lasts 13 bit times, never 24.
// - Transmitter enable low then high queues idle sent before a later break.
// - Idle character before a LIN break occupies 10 bit times.
// - Receiver samples the line sixteen times per bit.
// - LIN slave header over 57 bits sets header error, interrupts, stays muted.
// - Time-out during ID stop bit samples 9 to 15 never wakes the receiver.
// - On header time-out header detect stays clear while header error sets.
// - On header time-out header length register loads zero.
// - Header error cleared by status access followed by data register read.
// - Receive ready flag raises interrupt; unmuted, every data byte does.
// - Software setting mute bit mutes receiver until the next header.
`timescale 1ns/1ps
`include "luhm_defines.vh"

module luhm_uart (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [15:0] baud_div,
  input  wire        word_len,
  input  wire        lin_enable,
  input  wire        lin_slave,
  input  wire        transmitter_enable_bit,
  input  wire        send_break_bit,
  input  wire [7:0]  tx_data,
  input  wire        tx_data_write,
  input  wire        receiver_mute_set,
  input  wire        status_access,
  input  wire        data_read,
  input  wire        rx_line,
  output reg         tx_line,
  output wire        tx_ready,
  output reg  [7:0]  serial_data_reg,
  output reg         receive_ready_flag,
  output reg         header_error_flag,
  output reg         header_detect_flag,
  output reg  [7:0]  header_length_reg,
  output reg         receiver_mute_bit,
  output wire        irq
);

  wire        tick;
  reg         tx_state;
  reg  [1:0]  tx_kind;
  reg  [10:0] tx_shift;
  reg  [3:0]  tx_bits;
  reg  [3:0]  tx_smp;
  reg  [7:0]  tx_buf;
  reg         tx_buf_full;
  reg         brk_req;
  reg         idle_req;
  reg         sbk_prev;
  reg         te_prev;
  wire        lin_master;
  wire [3:0]  brk_bits;
  wire [3:0]  char_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // Oversampling tick
  luhm_tick u_tick (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .baud_div (baud_div),
    .tick     (tick)
  );

  assign lin_master = lin_enable & ~word_len;
  assign brk_bits   = lin_master ? `LUHM_BRK_BITS_LIN :
                      (word_len ? `LUHM_BRK_BITS_M1 : `LUHM_BRK_BITS_M0);
  assign char_bits  = word_len ? `LUHM_CHAR_BITS_M1 : `LUHM_CHAR_BITS_M0;
  assign tx_ready   = ~tx_buf_full;

  ////////////////////////////////////////////////////////////////////////////////
  // Request capture
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sbk_prev    <= 1'b0;
      te_prev     <= 1'b0;
      brk_req     <= 1'b0;
      idle_req    <= 1'b0;
      tx_buf      <= 8'h00;
      tx_buf_full <= 1'b0;
    end else begin
      sbk_prev <= send_break_bit;
      te_prev  <= transmitter_enable_bit;
      if (send_break_bit && !sbk_prev) begin
        brk_req <= 1'b1;
      end else if (tick && tx_state == `LUHM_TX_IDLE && !idle_req && transmitter_enable_bit) begin
        brk_req <= 1'b0;
      end
      if (transmitter_enable_bit && !te_prev) begin
        idle_req <= 1'b1;
      end else if (tick && tx_state == `LUHM_TX_IDLE) begin
        idle_req <= 1'b0;
      end
      if (tx_data_write && !tx_buf_full) begin
        tx_buf      <= tx_data;
        tx_buf_full <= 1'b1;
      end else if (tick && tx_state == `LUHM_TX_IDLE && transmitter_enable_bit &&
                   !idle_req && !brk_req) begin
        tx_buf_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter: characters start only on a tick, so every bit spans 16 ticks
  always @(posedge ref_clk) begin
    if (!resetn) begin
      tx_state <= `LUHM_TX_IDLE;
      tx_kind  <= `LUHM_KIND_DATA;
      tx_shift <= 11'h7ff;
      tx_bits  <= 4'h0;
      tx_smp   <= 4'h0;
      tx_line  <= 1'b1;
    end else if (!transmitter_enable_bit) begin
      tx_state <= `LUHM_TX_IDLE;
      tx_line  <= 1'b1;
    end else if (tick) begin
      case (tx_state)
        `LUHM_TX_IDLE: begin
          tx_smp <= 4'h0;
          if (idle_req) begin
            tx_state <= `LUHM_TX_RUN;
            tx_kind  <= `LUHM_KIND_IDLE;
            tx_bits  <= char_bits;
            tx_line  <= 1'b1;
          end else if (brk_req) begin
            tx_state <= `LUHM_TX_RUN;
            tx_kind  <= `LUHM_KIND_BREAK;
            tx_bits  <= brk_bits;
            tx_line  <= 1'b0;
          end else if (tx_buf_full) begin
            tx_state <= `LUHM_TX_RUN;
            tx_kind  <= `LUHM_KIND_DATA;
            tx_bits  <= char_bits;
            tx_shift <= {2'b11, tx_buf, 1'b0};
            tx_line  <= 1'b0;
          end else begin
            tx_line <= 1'b1;
          end
        end
        `LUHM_TX_RUN: begin
          tx_smp <= tx_smp + 4'h1;
          if (tx_smp == `LUHM_SMP_LAST) begin
            if (tx_bits == 4'h1) begin
              if (tx_kind == `LUHM_KIND_BREAK && send_break_bit) begin
                tx_bits <= brk_bits;
                tx_line <= 1'b0;
              end else begin
                tx_state <= `LUHM_TX_IDLE;
                tx_line  <= 1'b1;
              end
            end else begin
              tx_bits <= tx_bits - 4'h1;
              if (tx_kind == `LUHM_KIND_DATA) begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_line  <= tx_shift[1];
              end
            end
          end
        end
        default: tx_state <= `LUHM_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver: 16 samples per bit, decision at the ninth sample
  reg         rx_state;
  reg  [3:0]  rx_smp;
  reg  [3:0]  rx_bit;
  reg  [7:0]  rx_shift;
  reg         rx_prev;
  reg         rx_byte_ev;
  reg         rx_stop_ok;
  reg         rx_stop_end_ev;
  reg  [7:0]  low_run;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      rx_state       <= `LUHM_RX_IDLE;
      rx_smp         <= 4'h0;
      rx_bit         <= 4'h0;
      rx_shift       <= 8'h00;
      rx_prev        <= 1'b1;
      rx_byte_ev     <= 1'b0;
      rx_stop_ok     <= 1'b0;
      rx_stop_end_ev <= 1'b0;
      low_run        <= 8'h00;
    end else begin
      rx_byte_ev     <= 1'b0;
      rx_stop_end_ev <= 1'b0;
      if (tick) begin
        rx_prev <= rx_line;
        if (rx_line) begin
          low_run <= 8'h00;
        end else if (low_run != `LUHM_BRK_DET_TICKS) begin
          low_run <= low_run + 8'h01;
        end
        case (rx_state)
          `LUHM_RX_IDLE: begin
            rx_smp <= 4'h1;
            rx_bit <= 4'h0;
            if (!rx_line && rx_prev) begin
              rx_state <= `LUHM_RX_FRAME;
            end
          end
          `LUHM_RX_FRAME: begin
            rx_smp <= rx_smp + 4'h1;
            if (rx_smp == `LUHM_SMP_MID) begin
              if (rx_bit == 4'h0 && rx_line) begin
                rx_state <= `LUHM_RX_IDLE;
              end else if (rx_bit == `LUHM_RX_STOP_BIT) begin
                rx_byte_ev <= 1'b1;
                rx_stop_ok <= rx_line;
              end else if (rx_bit != 4'h0) begin
                rx_shift <= {rx_line, rx_shift[7:1]};
              end
            end
            if (rx_smp == `LUHM_SMP_LAST) begin
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == `LUHM_RX_STOP_BIT) begin
                rx_stop_end_ev <= 1'b1;
                rx_state       <= `LUHM_RX_IDLE;
              end
            end
          end
          default: rx_state <= `LUHM_RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // LIN slave header tracking and flags
  reg  [1:0]  h_state;
  reg  [9:0]  hdr_cnt;
  reg         status_seen;
  wire        hdr_active;
  wire        brk_seen;
  wire        hdr_tmo;
  wire        hdr_done;
  wire        clr_access;
  wire        byte_good;
  wire [9:0]  hdr_bits;

  assign hdr_active = (h_state != `LUHM_H_WAIT);
  assign brk_seen   = lin_enable && lin_slave && tick && !rx_line &&
                      (low_run == `LUHM_BRK_DET_TICKS - 8'h01);
  assign hdr_tmo    = hdr_active && (hdr_cnt >= `LUHM_HDR_TMO_TICKS);
  assign hdr_done   = (h_state == `LUHM_H_STOP) && rx_stop_end_ev && !hdr_tmo;
  assign clr_access = data_read && status_seen;
  assign byte_good  = rx_byte_ev && (rx_stop_ok || rx_shift != 8'h00);
  assign hdr_bits   = hdr_cnt >> 4;
  assign irq        = receive_ready_flag | header_error_flag | header_detect_flag;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      h_state            <= `LUHM_H_WAIT;
      hdr_cnt            <= 10'h000;
      status_seen        <= 1'b0;
      serial_data_reg    <= 8'h00;
      receive_ready_flag <= 1'b0;
      header_error_flag  <= 1'b0;
      header_detect_flag <= 1'b0;
      header_length_reg  <= `LUHM_HDR_LEN_ZERO;
      receiver_mute_bit  <= 1'b0;
    end else begin
      if (status_access) begin
        status_seen <= 1'b1;
      end else if (data_read) begin
        status_seen <= 1'b0;
      end
      if (brk_seen) begin
        h_state <= `LUHM_H_SYNC;
        hdr_cnt <= {2'b00, `LUHM_BRK_DET_TICKS};
      end else if (hdr_tmo) begin
        h_state <= `LUHM_H_WAIT;
      end else if (hdr_active) begin
        if (tick) begin
          hdr_cnt <= hdr_cnt + 10'h001;
        end
        case (h_state)
          `LUHM_H_SYNC: if (byte_good) h_state <= `LUHM_H_ID;
          `LUHM_H_ID:   if (byte_good) h_state <= `LUHM_H_STOP;
          `LUHM_H_STOP: if (hdr_done) h_state <= `LUHM_H_WAIT;
          default:      h_state <= `LUHM_H_WAIT;
        endcase
      end
      if (byte_good) begin
        serial_data_reg <= rx_shift;
      end
      if (byte_good && !receiver_mute_bit) begin
        receive_ready_flag <= 1'b1;
      end else if (clr_access) begin
        receive_ready_flag <= 1'b0;
      end
      if (hdr_tmo && !brk_seen) begin
        header_error_flag <= 1'b1;
        header_length_reg <= `LUHM_HDR_LEN_ZERO;
      end else if (clr_access) begin
        header_error_flag <= 1'b0;
      end
      if (hdr_done && !brk_seen) begin
        header_detect_flag <= 1'b1;
        header_length_reg  <= hdr_bits[7:0];
      end else if (clr_access) begin
        header_detect_flag <= 1'b0;
      end
      if (receiver_mute_set) begin
        receiver_mute_bit <= 1'b1;
      end else if (hdr_done && !brk_seen) begin
        receiver_mute_bit <= 1'b0;
      end
    end
  end

endmodule // luhm_uart

/* File: luhm_uart_monitor.sv */
/*
 * Checker of the serial transceiver: break lengths, header time-out, flags.
 * Assumes binding to luhm_uart and a single ref_clk domain.
 */
`timescale 1ns/1ps

module luhm_uart_monitor (
  input wire        ref_clk,
  input wire        resetn,
  input wire [15:0] baud_div,
  input wire        word_len,
  input wire        lin_enable,
  input wire        status_access,
  input wire        data_read,
  input wire        receiver_mute_set,
  input wire        tx_data_write,
  input wire        tx_line,
  input wire        tx_ready,
  input wire        receive_ready_flag,
  input wire        header_error_flag,
  input wire        header_detect_flag,
  input wire [7:0]  header_length_reg,
  input wire        receiver_mute_bit,
  input wire        irq
);
  logic [19:0] low_cnt;
  logic        stat_seen;
  wire  [19:0] bitc = ({4'h0, baud_div} + 20'h1) << 4;
  wire  [3:0]  brk_bits = (lin_enable && !word_len) ? 4'hd : (word_len ? 4'hb : 4'ha);

  // Low run length and pending status access
  always @(posedge ref_clk) begin
    if (!resetn) begin
      low_cnt <= 20'h0;
      stat_seen <= 1'b0;
    end else begin
      low_cnt <= tx_line ? 20'h0 : low_cnt + 20'h1;
      stat_seen <= status_access | (stat_seen & !data_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_brk_len;
    $rose(tx_line) && low_cnt > bitc * 9 |-> low_cnt == bitc * brk_bits;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");
  property p_ready;
    tx_data_write && tx_ready |=> !tx_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("write not taken");
  property p_irq_or;
    irq == (receive_ready_flag | header_error_flag | header_detect_flag);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq mismatch");
  property p_tmo_len;
    $rose(header_error_flag) |-> header_length_reg == 8'h00;
  endproperty
  a_tmo_len: assert property (p_tmo_len) else $error("length not zero");
  property p_tmo_nodet;
    $rose(header_error_flag) |-> !$rose(header_detect_flag);
  endproperty
  a_tmo_nodet: assert property (p_tmo_nodet) else $error("detect set");
  property p_tmo_mute;
    $rose(header_error_flag) && $past(receiver_mute_bit) |-> receiver_mute_bit [*8];
  endproperty
  a_tmo_mute: assert property (p_tmo_mute) else $error("woke on time-out");
  property p_mute_set;
    receiver_mute_set |=> receiver_mute_bit;
  endproperty
  a_mute_set: assert property (p_mute_set) else $error("mute not set");
  property p_mute_quiet;
    receiver_mute_bit && $past(receiver_mute_bit) |-> !$rose(receive_ready_flag);
  endproperty
  a_mute_quiet: assert property (p_mute_quiet) else $error("ready while muted");
  property p_clr;
    data_read && stat_seen |=> !header_error_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("error flag kept");
  property p_hef_hold;
    $fell(header_error_flag) |-> $past(data_read);
  endproperty
  a_hef_hold: assert property (p_hef_hold) else $error("error flag lost");
endmodule // luhm_uart_monitor

bind luhm_uart luhm_uart_monitor u_mon (
  .ref_clk, .resetn, .baud_div, .word_len, .lin_enable, .status_access, .data_read,
  .receiver_mute_set, .tx_data_write, .tx_line, .tx_ready, .receive_ready_flag,
  .header_error_flag, .header_detect_flag, .header_length_reg, .receiver_mute_bit, .irq
);

/* File: luhm_node.sv */
/*
 * Far serial node: drives the receive line with bytes and LIN headers.
 * Assumes callers enter its tasks just after a falling clock edge.
 */
`timescale 1ns/1ps

module luhm_node (
  input  wire ref_clk,
  output reg  rx_line
);
  initial rx_line = 1'b1;

  task hold(input logic lvl, input int cyc);
    begin
      rx_line = lvl;
      repeat (cyc) @(negedge ref_clk);
    end
  endtask

  // Start, eight bits LSB first, stop
  task send_byte(input logic [7:0] b, input int bc);
    begin
      hold(1'b0, bc);
      for (int i = 0; i < 8; i++) hold(b[i], bc);
      hold(1'b1, bc);
    end
  endtask

  // Break, delimiter, sync, gap, identifier
  task send_header(input logic [7:0] id, input int bc, input int gap);
    begin
      hold(1'b0, 13 * bc);
      hold(1'b1, bc);
      send_byte(8'h55, bc);
      hold(1'b1, gap);
      send_byte(id, bc);
    end
  endtask
endmodule // luhm_node

/* File: luhm_uart_bench.sv */
/*
 * Self-checking bench of the serial transceiver with a far node model.
 * Assumes luhm_uart, luhm_node and the bound checker are compiled first.
 */
`timescale 1ns/1ps

module luhm_uart_bench;
  reg         ref_clk, resetn, word_len, lin_enable, lin_slave;
  reg         transmitter_enable_bit, send_break_bit, tx_data_write;
  reg         receiver_mute_set, status_access, data_read;
  reg  [15:0] baud_div;
  reg  [7:0]  tx_data, b;
  wire        rx_line, tx_line, tx_ready, receive_ready_flag, header_error_flag;
  wire        header_detect_flag, receiver_mute_bit, irq;
  wire [7:0]  serial_data_reg, header_length_reg;
  int         error_cnt, num_checks, cyc, bc, lo, t;
  int         exp_q[$];

  luhm_uart u_dut (
    .ref_clk, .resetn, .baud_div, .word_len, .lin_enable, .lin_slave,
    .transmitter_enable_bit, .send_break_bit, .tx_data, .tx_data_write,
    .receiver_mute_set, .status_access, .data_read, .rx_line, .tx_line, .tx_ready,
    .serial_data_reg, .receive_ready_flag, .header_error_flag, .header_detect_flag,
    .header_length_reg, .receiver_mute_bit, .irq
  );
  luhm_node u_node (.ref_clk, .rx_line);

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        error_cnt++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic pulse(ref reg s);
    begin
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
      @(negedge ref_clk);
    end
  endtask

  task brk(input int bits);
    begin
      exp_q.push_back(bits * bc);
      pulse(send_break_bit);
    end
  endtask

  task wait_q;
    for (int i = 0; i < 40 * bc && (exp_q.size() > 0 || tx_line !== 1'b1); i++)
      @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      end_of_test;
    end
  end

  // Low runs on the transmit line against noted lengths
  always @(posedge ref_clk) begin
    if (resetn && tx_line === 1'b0) lo++;
    else if (lo != 0) begin
      chk(lo, exp_q.size() ? exp_q.pop_front() : 0);
      lo = 0;
    end
  end

  initial begin
    {resetn, word_len, lin_enable, send_break_bit, tx_data_write, tx_data} = 0;
    {receiver_mute_set, status_access, data_read, baud_div} = 0;
    lin_slave = 1'b1;
    transmitter_enable_bit = 1'b1;
    void'($urandom(98211));
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    for (int k = 0; k < 2; k++) begin
      baud_div = k ? 16'h0 : 16'($urandom_range(3, 1));
      bc = 16 * (baud_div + 1);
      for (int m = 0; m < 3; m++) begin
        word_len = (m == 1);
        lin_enable = (m == 2);
        repeat ($urandom_range(bc, 1)) @(negedge ref_clk);
        brk(m == 0 ? 10 : (m == 1 ? 11 : 13));
        wait_q;
      end
    end
    // Break requested while a character shifts out
    {word_len, lin_enable, tx_data} = 10'h0ff;
    exp_q.push_back(bc);
    pulse(tx_data_write);
    for (int i = 0; i < bc && tx_ready !== 1'b1; i++) @(negedge ref_clk);
    brk(10);
    wait_q;
    // Idle then LIN break with nothing between
    lin_enable = 1'b1;
    pulse(transmitter_enable_bit);
    transmitter_enable_bit = 1'b1;
    exp_q.push_back(13 * bc);
    send_break_bit = 1'b1;
    @(negedge ref_clk);
    send_break_bit = 1'b0;
    for (t = 1; t < 20 * bc && tx_line !== 1'b0; t++) @(negedge ref_clk);
    chk(t >= 10 * bc && t <= 10 * bc + bc / 16 + 3, 1);
    wait_q;
    // Receive path
    b = 8'($urandom);
    u_node.send_byte(b, bc);
    repeat (4) @(negedge ref_clk);
    chk(receive_ready_flag, 1);
    chk(serial_data_reg, b);
    pulse(status_access);
    pulse(data_read);
    chk(irq, 0);
    pulse(receiver_mute_set);
    chk(receiver_mute_bit, 1);
    u_node.send_byte(8'($urandom), bc);
    repeat (4) @(negedge ref_clk);
    chk(receive_ready_flag, 0);
    u_node.send_header(8'h3c, bc, 40 * bc);
    repeat (4) @(negedge ref_clk);
    chk({header_error_flag, header_detect_flag, receiver_mute_bit, irq}, 4'hb);
    chk(header_length_reg, 8'h00);
    pulse(data_read);
    chk(header_error_flag, 1);
    pulse(status_access);
    pulse(data_read);
    chk(header_error_flag, 0);
    u_node.send_header(8'h3c, bc, bc);
    repeat (4) @(negedge ref_clk);
    chk({header_detect_flag, receiver_mute_bit}, 2'h2);
    chk(header_length_reg >= 8'd33 && header_length_reg <= 8'd37, 1);
    // Time-out inside the identifier stop bit, samples 9 to 15
    pulse(status_access);
    pulse(data_read);
    pulse(receiver_mute_set);
    u_node.send_header(8'h3c, bc, 23 * bc + 4);
    repeat (4) @(negedge ref_clk);
    chk({header_error_flag, header_detect_flag, receiver_mute_bit}, 3'h5);
    chk(receive_ready_flag, 0);
    chk(header_length_reg, 8'h00);
    // No break left unsent and none extra
    chk(exp_q.size(), 0);
    end_of_test;
  end
endmodule // luhm_uart_bench
